// *** burst_mask_params.svh ***
// Constants for the byte-masked burst write path.
// Assumes inclusion by the package and the design file by bare name.
`ifndef BURST_MASK_PARAMS_SVH
`define BURST_MASK_PARAMS_SVH

`define DATA_W        36
`define LANE_W        9
`define LANES         4
`define ADDR_W        4
`define MEM_DEPTH     16
`define FIFO_DEPTH    32
`define FIFO_AW       5
`define ENTRY_W       44
`define ENT_MASK_LSB  36
`define ENT_ADDR_LSB  40
`define READY_MARGIN  6'h03
`define ADDR_STEP     4'h1
`define MASK_NONE     4'hf
`define LANES_NONE    4'h0
`define NARROW_ENABLE 4'h3
`define ADDR_RST      4'h0
`define DATA_RST      36'h000000000

`endif

// *** burst_mask_pkg.sv ***
// Types shared by the burst write path.
// Assumes burst_mask_params.svh is on the include path.
`include "burst_mask_params.svh"

package burst_mask_pkg;
    typedef enum logic [0:0] {
        WR_IDLE   = 1'b0,
        WR_SECOND = 1'b1
    } wr_state_type;

    typedef logic [`LANES-1:0]   lane_type;
    typedef logic [`ADDR_W-1:0]  addr_type;
    typedef logic [`DATA_W-1:0]  word_type;
endpackage

// *** burst_mask_write.sv ***
// Byte-masked two-beat write path: beat capture, 32-entry FIFO, lane merge.
// Assumes all inputs synchronous to sys_clk; one clock cycle per data beat.
//
// Summary of operation
// RL1: Write starts when select is low; first beat taken then, second next cycle.
// RL2: Byte selects are sampled separately with each data word of the burst.
// RL3: Narrow, both selects low: full 18-bit word is stored.
// RL4: Narrow, select zero only low: bits 8..0 written, 17..9 kept.
// RL5: Narrow, select one only low: bits 17..9 written, 8..0 kept.
// RL6: Narrow, all selects high: word untouched on either beat.
// RL7: Wide, all four selects low: full 36-bit word stored.
// RL8: Wide, select zero only low: bits 8..0 written, rest kept.
// RL9: Wide, select one, two or three alone writes its own nine bits.
// RL10: Wide, all selects high: word untouched on either beat.
// RL11: Selects may change between beats; each beat uses its own mask.
// RL12: After power-up the write port is deselected, outputs not driven.
// RL13: First beat uses latched address, second beat address plus one.
// RL14: Write data registered on clock edges; read launch timing is elsewhere.
// RL15: Controller should park clocks in a known level when stopping them.
// RL16: Wide, any mix of low selects writes exactly those nine-bit lanes.
`timescale 1ns/1ps
`include "burst_mask_params.svh"

// Plain FIFO; in_ready drops only when truly full
module lane_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [AW:0]           level
);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Handshakes on both sides
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = store[rd_ptr_r];
    assign level     = count_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage has no reset; only pointers and count carry state
    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap naturally at a power-of-two depth
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module burst_mask_write
    import burst_mask_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               write_port_select_n,
    input  wire logic [`ADDR_W-1:0] wr_addr,
    input  wire logic [`DATA_W-1:0] wr_data,
    input  wire logic [`LANES-1:0]  byte_lane_write_select_n,
    input  wire logic               wide_config_strap,
    input  wire logic               array_busy,
    input  wire logic [`ADDR_W-1:0] peek_addr,
    output logic                    write_ready_r,
    output logic                    port_idle_r,
    output logic                    dq_oe_r,
    output logic                    commit_valid_r,
    output logic [`ADDR_W-1:0]      commit_addr_r,
    output logic [`LANES-1:0]       commit_lanes_r,
    output logic [`DATA_W-1:0]      peek_data_r
);
    word_type              mem [`MEM_DEPTH];
    wr_state_type          state_r;
    wr_state_type          state_nxt;
    addr_type              start_addr_r;
    logic                  wide_r;
    logic                  strap_taken_r;
    logic                  start_ok;
    logic                  push_valid;
    logic [`ENTRY_W-1:0]   push_data;
    logic                  fifo_in_ready;
    logic                  pop_valid;
    logic                  pop_ready;
    logic [`ENTRY_W-1:0]   pop_data;
    logic [`FIFO_AW:0]     fifo_level;
    addr_type              pop_addr;
    lane_type              pop_mask;
    word_type              pop_word;
    lane_type              pop_lanes;
    word_type              commit_data_r;
    lane_type              commit_mask_r;
    word_type              prev_word_r;

    // Active-low selects to lane enables; narrow mode owns lanes 0 and 1
    function automatic lane_type lane_enables(lane_type sel_n, logic wide);
        lane_type en;
        en = ~sel_n;
        if (!wide) begin
            en = en & `NARROW_ENABLE;
        end
        return en;
    endfunction

    // Merge new lanes over the old word; disabled lanes keep old bits
    function automatic word_type lane_merge(word_type old_w, word_type new_w,
                                            lane_type en);
        word_type w;
        w = old_w;
        for (int i = 0; i < `LANES; i++) begin
            if (en[i]) begin
                w[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W];
            end
        end
        return w;
    endfunction

    // Width strap caught once after reset release, never mid-operation
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_taken_r <= 1'b0;
            wide_r        <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            wide_r        <= wide_config_strap;
        end
    end

    // Beat capture: a start is refused while the FIFO lacks room for two
    assign start_ok = (state_r == WR_IDLE) && !write_port_select_n
                      && write_ready_r && strap_taken_r;

    always_comb begin
        state_nxt  = state_r;
        push_valid = 1'b0;
        push_data  = {wr_addr, byte_lane_write_select_n, wr_data};
        case (state_r)
            WR_IDLE: begin
                if (start_ok) begin
                    push_valid = 1'b1; // RL1
                    state_nxt  = WR_SECOND;
                end
            end
            WR_SECOND: begin
                push_valid = 1'b1;
                // Second beat carries its own mask and the next address
                push_data  = {addr_type'(start_addr_r + `ADDR_STEP), // RL13
                              byte_lane_write_select_n, wr_data}; // RL2 RL11
                state_nxt  = WR_IDLE;
            end
            default: begin
                state_nxt = WR_IDLE;
            end
        endcase
    end

    // Burst sequencer and latched start address
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r      <= WR_IDLE;
            start_addr_r <= `ADDR_RST;
        end else begin
            state_r <= state_nxt;
            if (start_ok) begin
                start_addr_r <= wr_addr; // RL13
            end
        end
    end

    // Ready leaves margin for an in-flight beat plus a whole new burst
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            write_ready_r <= 1'b0;
            port_idle_r   <= 1'b1; // RL12
            dq_oe_r       <= 1'b0; // RL12
        end else begin
            write_ready_r <= (fifo_level <= (`FIFO_DEPTH - `READY_MARGIN));
            port_idle_r   <= (state_nxt == WR_IDLE) && !push_valid
                             && !pop_valid;
            dq_oe_r       <= 1'b0; // Read drivers live outside this block
        end
    end

    lane_fifo #(
        .WIDTH (`ENTRY_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data),
        .level     (fifo_level)
    );

    // Array commit stalls while busy, so the FIFO can really fill
    assign pop_ready = !array_busy;
    assign pop_addr  = pop_data[`ENT_ADDR_LSB +: `ADDR_W];
    assign pop_mask  = pop_data[`ENT_MASK_LSB +: `LANES];
    assign pop_word  = pop_data[`DATA_W-1:0];
    assign pop_lanes = lane_enables(pop_mask, wide_r); // RL6 RL10

    // Lane-masked store; all-high masks leave the word as it was
    always_ff @(posedge sys_clk) begin
        if (pop_valid && pop_ready) begin
            mem[pop_addr] <= lane_merge(mem[pop_addr], pop_word,
                                        pop_lanes); // RL3 RL4 RL5 RL7
        end // RL8 RL9 RL16
        peek_data_r <= mem[peek_addr];
        prev_word_r <= mem[pop_addr];
    end

    // Commit report, one pulse per beat written; data is registered first
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            commit_valid_r <= 1'b0;
            commit_addr_r  <= `ADDR_RST;
            commit_lanes_r <= `LANES_NONE;
            commit_mask_r  <= `MASK_NONE;
            commit_data_r  <= `DATA_RST;
        end else begin
            commit_valid_r <= pop_valid && pop_ready; // RL14
            commit_addr_r  <= pop_addr;
            commit_lanes_r <= pop_lanes;
            commit_mask_r  <= pop_mask;
            commit_data_r  <= pop_word;
        end
    end

    // Checks on the burst sequencing and the lane merge
    property p_start_beat;
        @(posedge sys_clk) disable iff (!reset_n)
        start_ok |-> push_valid && fifo_in_ready
            && push_data[`ENT_ADDR_LSB +: `ADDR_W] == wr_addr;
    endproperty
    a_start_beat: assert property (p_start_beat) // RL1
        else $error("first beat not pushed at start");

    property p_second_addr;
        @(posedge sys_clk) disable iff (!reset_n)
        start_ok |=> push_valid && push_data[`ENT_ADDR_LSB +: `ADDR_W]
            == addr_type'($past(wr_addr) + `ADDR_STEP);
    endproperty
    a_second_addr: assert property (p_second_addr) // RL13
        else $error("second beat address not start plus one");

    property p_beat_mask;
        @(posedge sys_clk) disable iff (!reset_n)
        state_r == WR_SECOND |-> push_data[`ENT_MASK_LSB +: `LANES]
            == byte_lane_write_select_n && $past(start_ok);
    endproperty
    a_beat_mask: assert property (p_beat_mask) // RL2
        else $error("second beat mask not its own");

    property p_narrow_full;
        @(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && !wide_r && commit_mask_r[1:0] == 2'h0 |->
            mem[commit_addr_r][17:0] == commit_data_r[17:0];
    endproperty
    a_narrow_full: assert property (p_narrow_full) // RL3
        else $error("narrow full word not stored");

    property p_narrow_low;
        @(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && !wide_r && commit_mask_r[1:0] == 2'h2 |->
            mem[commit_addr_r][8:0] == commit_data_r[8:0]
            && mem[commit_addr_r][17:9] == prev_word_r[17:9];
    endproperty
    a_narrow_low: assert property (p_narrow_low) // RL4
        else $error("narrow low lane merge wrong");

    property p_narrow_high;
        @(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && !wide_r && commit_mask_r[1:0] == 2'h1 |->
            mem[commit_addr_r][17:9] == commit_data_r[17:9]
            && mem[commit_addr_r][8:0] == prev_word_r[8:0];
    endproperty
    a_narrow_high: assert property (p_narrow_high) // RL5
        else $error("narrow high lane merge wrong");

    property p_no_write;
        @(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && (commit_mask_r == `MASK_NONE
            || (!wide_r && commit_mask_r[1:0] == 2'h3)) |->
            mem[commit_addr_r] == prev_word_r;
    endproperty
    a_no_write: assert property (p_no_write) // RL6 RL10
        else $error("masked beat altered memory");

    property p_wide_full;
        @(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && wide_r && commit_mask_r == 4'h0 |->
            mem[commit_addr_r] == commit_data_r;
    endproperty
    a_wide_full: assert property (p_wide_full) // RL7
        else $error("wide full word not stored");

    property p_wide_lane0;
        @(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && wide_r && commit_mask_r == 4'he |->
            mem[commit_addr_r][8:0] == commit_data_r[8:0]
            && mem[commit_addr_r][35:9] == prev_word_r[35:9];
    endproperty
    a_wide_lane0: assert property (p_wide_lane0) // RL8
        else $error("wide lane zero merge wrong");

    property p_wide_lane3;
        @(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && wide_r && commit_mask_r == 4'h7 |->
            mem[commit_addr_r][35:27] == commit_data_r[35:27]
            && mem[commit_addr_r][26:0] == prev_word_r[26:0];
    endproperty
    a_wide_lane3: assert property (p_wide_lane3) // RL9 RL16
        else $error("wide lane three merge wrong");

    property p_powerup;
        @(posedge sys_clk)
        $rose(reset_n) |-> port_idle_r && !dq_oe_r && !commit_valid_r;
    endproperty
    a_powerup: assert property (p_powerup) // RL12
        else $error("not deselected after reset");

    property p_commit_latency;
        @(posedge sys_clk) disable iff (!reset_n)
        start_ok && fifo_level == '0 && !array_busy ##1 (!array_busy)[*2]
            |-> commit_valid_r ##1 commit_valid_r;
    endproperty
    a_commit_latency: assert property (p_commit_latency) // RL14
        else $error("beats not committed on time");

    c_wide_burst: cover property (@(posedge sys_clk) disable iff (!reset_n)
        start_ok && wide_r ##1 state_r == WR_SECOND);
    c_mask_change: cover property (@(posedge sys_clk) disable iff (!reset_n)
        start_ok ##1 push_data[`ENT_MASK_LSB +: `LANES]
            != $past(byte_lane_write_select_n));
    c_fifo_full: cover property (@(posedge sys_clk) disable iff (!reset_n)
        !fifo_in_ready);
    c_narrow_byte: cover property (@(posedge sys_clk) disable iff (!reset_n)
        commit_valid_r && !wide_r && commit_lanes_r == 4'h1);
endmodule

// *** wr_ctrl_model.sv ***
// Memory controller model driving the write port of the burst path.
// Assumes its tasks are entered shortly after a rising edge of sys_clk.
`timescale 1ns/1ps

module wr_ctrl_model
    import burst_mask_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic write_ready_r,
    output logic      write_port_select_n,
    output addr_type  wr_addr,
    output word_type  wr_data,
    output lane_type  byte_lane_write_select_n
);
    // Power-up: port deselected
    initial begin
        write_port_select_n      = 1'b1;
        wr_addr                  = 4'h0;
        wr_data                  = 36'h000000000;
        byte_lane_write_select_n = 4'hf;
    end

    // Idle lines flip every cycle so stale values are never mistaken
    task automatic drive_idle();
        write_port_select_n      = 1'b1;
        wr_addr                  = ~wr_addr;
        wr_data                  = ~wr_data;
        byte_lane_write_select_n = ~byte_lane_write_select_n;
    endtask

    task automatic idle_cycle();
        drive_idle();
        @(posedge sys_clk);
        #1;
    endtask

    // Two-beat burst; leaves beat 1 on the lines so bursts run back to back
    task automatic burst(input addr_type a, input word_type d0,
                         input lane_type s0, input word_type d1,
                         input lane_type s1);
        while (write_ready_r !== 1'b1) begin
            idle_cycle();
        end
        write_port_select_n      = 1'b0;
        wr_addr                  = a;
        wr_data                  = d0;
        byte_lane_write_select_n = s0;
        @(posedge sys_clk);
        #1;
        wr_addr                  = ~a; // Address is not looked at now
        wr_data                  = d1;
        byte_lane_write_select_n = s1;
        @(posedge sys_clk);
        #1;
    endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the byte-masked burst write path.
// Assumes the design files and wr_ctrl_model are compiled before it.
`timescale 1ns/1ps

module tb_top
    import burst_mask_pkg::*;
;
    logic     sys_clk;
    logic     reset_n;
    logic     wide_config_strap;
    logic     array_busy;
    addr_type peek_addr;
    logic     write_port_select_n;
    addr_type wr_addr;
    word_type wr_data;
    lane_type byte_lane_write_select_n;
    logic     write_ready_r;
    logic     port_idle_r;
    logic     dq_oe_r;
    logic     commit_valid_r;
    addr_type commit_addr_r;
    lane_type commit_lanes_r;
    word_type peek_data_r;
    int       n_mismatch;
    int       checked;
    logic [7:0] exp_q[$];
    word_type shadow[16];
    word_type cmp_mask;

    burst_mask_write uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .write_port_select_n(write_port_select_n), .wr_addr(wr_addr),
        .wr_data(wr_data),
        .byte_lane_write_select_n(byte_lane_write_select_n),
        .wide_config_strap(wide_config_strap), .array_busy(array_busy),
        .peek_addr(peek_addr), .write_ready_r(write_ready_r),
        .port_idle_r(port_idle_r), .dq_oe_r(dq_oe_r),
        .commit_valid_r(commit_valid_r), .commit_addr_r(commit_addr_r),
        .commit_lanes_r(commit_lanes_r), .peek_data_r(peek_data_r));

    wr_ctrl_model ctrl (.sys_clk(sys_clk), .write_ready_r(write_ready_r),
        .write_port_select_n(write_port_select_n), .wr_addr(wr_addr),
        .wr_data(wr_data),
        .byte_lane_write_select_n(byte_lane_write_select_n));

    // 100 MHz clock, never stopped; a stop would park it at one fixed level
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check_value(input logic [35:0] seen, input logic [35:0] exp,
                               input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    function automatic word_type rand_word();
        return word_type'({$urandom(), $urandom()});
    endfunction

    // Expected lane enables; narrow mode honours the two low selects only
    function automatic lane_type lanes_of(lane_type s);
        return ~s & (wide_config_strap ? 4'hf : 4'h3);
    endfunction

    // Update the shadow, note both beats' expectations, then drive
    task automatic do_burst(input addr_type a, input word_type d0,
                            input lane_type s0, input word_type d1,
                            input lane_type s1);
        addr_type a1;
        lane_type e[2];
        word_type d[2];
        a1 = addr_type'(a + 4'h1);
        e[0] = lanes_of(s0);
        e[1] = lanes_of(s1);
        d[0] = d0;
        d[1] = d1;
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 4; i++) begin
                if (e[b][i]) shadow[b ? a1 : a][9*i +: 9] = d[b][9*i +: 9];
            end
        end
        exp_q.push_back({a, e[0]});
        exp_q.push_back({a1, e[1]});
        ctrl.burst(a, d0, s0, d1, s1);
    endtask

    task automatic drain();
        int n;
        ctrl.idle_cycle();
        n = 0;
        while ((exp_q.size() != 0 || port_idle_r !== 1'b1) && n < 500) begin
            ctrl.idle_cycle();
            n++;
        end
        check_value(exp_q.size(), 0, "beats not committed");
    endtask

    // Read every word back through the peek port
    task automatic verify_mem();
        for (int a = 0; a < 16; a++) begin
            peek_addr = addr_type'(a);
            ctrl.idle_cycle();
            check_value(peek_data_r & cmp_mask, shadow[a] & cmp_mask,
                        "array word");
        end
    endtask

    task automatic do_reset(input logic strap);
        reset_n = 1'b0;
        wide_config_strap = strap;
        array_busy = 1'b0;
        cmp_mask = strap ? 36'hfffffffff : 36'h00003ffff;
        repeat (2) ctrl.idle_cycle();
        check_value({write_ready_r, port_idle_r, dq_oe_r, commit_valid_r},
                    4'h4, "reset outputs");
        reset_n = 1'b1;
        repeat (2) ctrl.idle_cycle();
        // Full-mask writes over every word, first one wrapping past 15
        for (int i = 0; i < 8; i++) begin
            do_burst(addr_type'(2 * i + 15), rand_word(), 4'h0,
                     rand_word(), 4'h0);
        end
        drain();
    endtask

    task automatic run_random(input int n);
        for (int i = 0; i < n; i++) begin
            // Stall only while there is room, so a waiting burst cannot hang
            array_busy = write_ready_r && 1'($urandom_range(0, 1));
            do_burst(addr_type'($urandom()), rand_word(),
                     lane_type'($urandom()), rand_word(),
                     lane_type'($urandom()));
            if ($urandom_range(0, 3) == 0) ctrl.idle_cycle();
        end
        array_busy = 1'b0;
        drain();
        verify_mem();
    endtask

    // Each commit is paired with the oldest note; output enable never rises
    always @(posedge sys_clk) begin
        #1;
        if (reset_n === 1'b1) begin
            check_value(dq_oe_r, 1'b0, "output enable");
            if (commit_valid_r === 1'b1) begin
                if (exp_q.size() == 0) begin
                    check_value(1'b1, 1'b0, "unexpected commit");
                end else begin
                    check_value({commit_addr_r, commit_lanes_r},
                                exp_q.pop_front(), "commit");
                end
            end
        end
    end

    // Watchdog at 20000 cycles, well above the few hundred of the run
    initial begin
        #200_000;
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        static lane_type wtab[5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hf};
        static lane_type ntab[4] = '{4'hc, 4'hd, 4'he, 4'hf};
        n_mismatch = 0;
        checked = 0;
        peek_addr = 4'h0;
        reset_n = 1'b0;
        wide_config_strap = 1'b1;
        array_busy = 1'b0;
        cmp_mask = 36'hfffffffff;
        void'($urandom(32'hea44));
        @(posedge sys_clk);
        #1;
        do_reset(1'b1);
        for (int i = 0; i < 5; i++) begin
            do_burst(addr_type'($urandom()), rand_word(), wtab[i],
                     rand_word(), wtab[(i + 1) % 5]);
        end
        drain();
        verify_mem();
        $display("test wide_lanes done");
        // Stall the array until the buffer refuses further bursts
        array_busy = 1'b1;
        for (int i = 0; i < 15; i++) begin
            do_burst(addr_type'($urandom()), rand_word(), 4'h0,
                     rand_word(), lane_type'($urandom()));
        end
        repeat (2) ctrl.idle_cycle();
        check_value({write_ready_r, port_idle_r}, 2'b00, "buffer full");
        check_value(exp_q.size(), 30, "commits while stalled");
        array_busy = 1'b0;
        drain();
        verify_mem();
        $display("test buffer_fill done");
        run_random(40);
        $display("test wide_random done");
        do_reset(1'b0);
        for (int i = 0; i < 4; i++) begin
            do_burst(addr_type'($urandom()), rand_word(), ntab[i],
                     rand_word(), ntab[(i + 1) % 4]);
        end
        drain();
        verify_mem();
        run_random(20);
        $display("test narrow done");
        tally_and_finish();
    end
endmodule
